// ### inc/multiturn_limit_counter_consts.svh
// Purpose: offsets, fields, reset values of the multiturn limit counter
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one word per register
// Notes:   definitions only; included by bare name
//
// How it works
// - absolute mode keeps count within 0..limit
// - negative turn from 0 loads limit
// - positive turn at limit wraps to 0
// - usage and limit act only after restart
// - drive limit defaults 65535; other selects wrapping in absolute mode
// - power-up limit difference raises mismatch alarm code
// - alarm code pins are active low
// - encoder write accepted only during mismatch alarm
// - encoder write copies limit unchecked, clears alarm
// - limit 65535 gives signed count -32768..32767
// - usage select: 0 absolute, 1 incremental
`ifndef MULTITURN_LIMIT_COUNTER_CONSTS_SVH
`define MULTITURN_LIMIT_COUNTER_CONSTS_SVH

// ===========================================================================
// register byte offsets
`define OFS_SETTING      5'h00
`define OFS_CONTROL      5'h04
`define OFS_STATE        5'h08
`define OFS_COUNT        5'h0C
`define OFS_ACTIVE_LIMIT 5'h10
`define OFS_IRQ_STATUS   5'h14
`define OFS_IRQ_MASK     5'h18

// ===========================================================================
// field positions
`define SETTING_USAGE_BIT   16
`define CONTROL_RESTART_BIT 0
`define CONTROL_ENC_WR_BIT  1
`define STATE_ALARM_BIT     0
`define STATE_VALID_BIT     1
`define STATE_USAGE_BIT     2
`define STATE_INIT_BIT      3
`define EVT_MISMATCH_BIT    0
`define EVT_WRAP_BIT        1
`define EVT_WR_DONE_BIT     2
`define EVT_WR_REFUSED_BIT  3
`define EVT_COUNT           4

// ===========================================================================
// reset values and special codes
`define LIMIT_DEFAULT      16'hFFFF
`define USAGE_DEFAULT      1'h0
`define USAGE_ABSOLUTE     1'h0
`define MASK_DEFAULT       4'h0

`endif

// ### inc/multiturn_limit_counter_pkg.sv
// Purpose: types shared by the multiturn limit counter files
// Assumes: nothing beyond the constants header
// Notes:   widths fixed at the documented 16-bit turn range
package multiturn_limit_counter_pkg;

    typedef logic [15:0] turns_type;

    typedef enum logic [0:0] {
        phase_init,
        phase_run
    } phase_type;

endpackage

// ### logic/multiturn_step.sv
// Purpose: next multiturn count for one revolution event
// Assumes: at most one of step_pos and step_neg counts; both cancel
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "multiturn_limit_counter_consts.svh"

module multiturn_step
    import multiturn_limit_counter_pkg::*;
(
    input  wire turns_type count,
    input  wire turns_type limit,
    input  wire logic      zero_based,
    input  wire logic      step_pos,
    input  wire logic      step_neg,
    output turns_type      next_count,
    output logic           wrapped
);

    always_comb begin
        next_count = count;
        wrapped    = 1'b0;
        if (step_pos && !step_neg) begin
            if (zero_based && count == limit) begin
                next_count = 16'h0000;
                wrapped    = 1'b1;
            end else begin
                // signed mode rolls 32767 into -32768 by plain overflow
                next_count = count + 16'h0001;
                wrapped    = (count == 16'h7FFF);
            end
        end else if (step_neg && !step_pos) begin
            if (zero_based && count == 16'h0000) begin
                next_count = limit;
                wrapped    = 1'b1;
            end else begin
                next_count = count - 16'h0001;
                wrapped    = (count == 16'h8000);
            end
        end
    end

endmodule
`default_nettype wire

// ### logic/multiturn_limit_counter.sv
// Purpose: multiturn revolution counter with wrap limit and mismatch alarm
// Assumes: revolution pulses and encoder values synchronous to mclk
// Notes:   a restart command stands in for a power cycle of the drive
`timescale 1ns/1ps
`default_nettype none
`include "multiturn_limit_counter_consts.svh"

module multiturn_limit_counter
    import multiturn_limit_counter_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rev_pos,
    input  wire logic        rev_neg,
    input  wire turns_type   encoder_limit,
    input  wire turns_type   encoder_turns,
    output logic             encoder_write_strobe,
    output turns_type        encoder_write_data,
    output turns_type        multiturn_count,
    output logic             count_valid,
    output logic             limit_mismatch_alarm,
    output logic             alarm_code_bit1_n,
    output logic             alarm_code_bit2_n,
    output logic             alarm_code_bit3_n,
    output logic             irq
);

    // =======================================================================
    // declarations
    phase_type                 phase;
    logic                      bus_ack;
    logic                      bus_req;
    logic                      wr_take;
    logic                      rd_take;
    logic [31:0]               next_readdata;
    logic [31:0]               setting_word;
    turns_type                 setting_limit;
    logic                      setting_usage;
    turns_type                 active_limit;
    logic                      active_usage;
    logic                      restart_req;
    logic                      enc_wr_req;
    logic                      zero_based;
    turns_type                 next_count;
    logic                      wrapped;
    logic                      step_en;
    logic [`EVT_COUNT-1:0]     irq_status;
    logic [`EVT_COUNT-1:0]     irq_mask;
    logic [`EVT_COUNT-1:0]     events;
    logic                      mismatch_now;

    // byte-lane merge, used for the setting word only
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  lanes
    );
        logic [31:0] merged;
        merged = old_word;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                merged[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return merged;
    endfunction

    // =======================================================================
    // avalon slave handshake
    // every access with ce high waits exactly one cycle so read data can come from flops
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign wr_take         = ce & avs_write & bus_ack;
    assign rd_take         = ce & avs_read & bus_ack;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_ack <= 1'b0;
        end else if (ce) begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // =======================================================================
    // read mux, captured in the wait cycle
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (avs_address == `OFS_SETTING) begin
            next_readdata[15:0]                = setting_limit;
            next_readdata[`SETTING_USAGE_BIT]  = setting_usage;
        end else if (avs_address == `OFS_STATE) begin
            next_readdata[`STATE_ALARM_BIT]    = limit_mismatch_alarm;
            next_readdata[`STATE_VALID_BIT]    = count_valid;
            next_readdata[`STATE_USAGE_BIT]    = active_usage;
            next_readdata[`STATE_INIT_BIT]     = (phase == phase_init);
        end else if (avs_address == `OFS_COUNT) begin
            next_readdata[15:0]                = multiturn_count;
        end else if (avs_address == `OFS_ACTIVE_LIMIT) begin
            next_readdata[15:0]                = active_limit;
        end else if (avs_address == `OFS_IRQ_STATUS) begin
            next_readdata[`EVT_COUNT-1:0]      = irq_status;
        end else if (avs_address == `OFS_IRQ_MASK) begin
            next_readdata[`EVT_COUNT-1:0]      = irq_mask;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && avs_read && !bus_ack) begin
            avs_readdata <= next_readdata;
        end
    end

    // =======================================================================
    // pending settings: stored now, used only from the next restart
    assign setting_word = lane_merge({15'h0000, setting_usage, setting_limit},
                                     avs_writedata, avs_byteenable);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            setting_limit <= `LIMIT_DEFAULT;
            setting_usage <= `USAGE_DEFAULT;
        end else if (wr_take && avs_address == `OFS_SETTING) begin
            // any 16-bit value is legal, so no range check is needed
            setting_limit <= setting_word[15:0];
            setting_usage <= setting_word[`SETTING_USAGE_BIT];
        end
    end

    // =======================================================================
    // command strobes from the control word
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            restart_req <= 1'b0;
            enc_wr_req  <= 1'b0;
        end else if (ce) begin
            restart_req <= wr_take && avs_address == `OFS_CONTROL
                           && avs_byteenable[0]
                           && avs_writedata[`CONTROL_RESTART_BIT];
            enc_wr_req  <= wr_take && avs_address == `OFS_CONTROL
                           && avs_byteenable[0]
                           && avs_writedata[`CONTROL_ENC_WR_BIT];
        end
    end

    // =======================================================================
    // init and run phases
    // init lasts one cycle after reset release or a restart command
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= phase_init;
        end else if (ce) begin
            case (phase)
                phase_init: begin
                    phase <= phase_run;
                end
                phase_run: begin
                    if (restart_req) begin
                        phase <= phase_init;
                    end
                end
                default: begin
                    phase <= phase_init;
                end
            endcase
        end
    end

    // active settings latch from the pending ones only during init
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_limit <= `LIMIT_DEFAULT;
            active_usage <= `USAGE_DEFAULT;
        end else if (ce && phase == phase_init) begin
            active_limit <= setting_limit;
            active_usage <= setting_usage;
        end
    end

    // =======================================================================
    // mismatch alarm
    // the comparison sees the pending value, which becomes active this cycle
    assign mismatch_now = (setting_limit != encoder_limit);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            limit_mismatch_alarm <= 1'b0;
        end else if (ce) begin
            if (phase == phase_init) begin
                limit_mismatch_alarm <= mismatch_now;
            end else if (enc_wr_req && limit_mismatch_alarm) begin
                limit_mismatch_alarm <= 1'b0;
            end
        end
    end

    // code pattern ON OFF ON, with ON at low level
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_code_bit1_n <= 1'b1;
            alarm_code_bit2_n <= 1'b1;
            alarm_code_bit3_n <= 1'b1;
        end else if (ce) begin
            alarm_code_bit1_n <= ~limit_mismatch_alarm;
            alarm_code_bit2_n <= 1'b1;
            alarm_code_bit3_n <= ~limit_mismatch_alarm;
        end
    end

    // =======================================================================
    // encoder limit write
    // the value is sent as it stands; a wrong setting is written unchecked
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            encoder_write_strobe <= 1'b0;
            encoder_write_data   <= `LIMIT_DEFAULT;
        end else if (ce) begin
            encoder_write_strobe <= enc_wr_req && limit_mismatch_alarm
                                    && phase == phase_run;
            if (enc_wr_req && limit_mismatch_alarm) begin
                encoder_write_data <= active_limit;
            end
        end
    end

    // =======================================================================
    // multiturn count
    // zero-based wrapping only in absolute mode with a non-default limit
    assign zero_based = (active_usage == `USAGE_ABSOLUTE)
                        && (active_limit != `LIMIT_DEFAULT);
    assign step_en    = ce && phase == phase_run;

    multiturn_step u_step (
        .count      (multiturn_count),
        .limit      (active_limit),
        .zero_based (zero_based),
        .step_pos   (rev_pos),
        .step_neg   (rev_neg),
        .next_count (next_count),
        .wrapped    (wrapped)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            multiturn_count <= 16'h0000;
        end else if (ce && phase == phase_init) begin
            // incremental use starts from zero at every restart
            if (setting_usage == `USAGE_ABSOLUTE) begin
                multiturn_count <= encoder_turns;
            end else begin
                multiturn_count <= 16'h0000;
            end
        end else if (step_en) begin
            multiturn_count <= next_count;
        end
    end

    // the count is reported only once the init comparison is done
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count_valid <= 1'b0;
        end else if (ce) begin
            count_valid <= (phase == phase_run) && !restart_req;
        end
    end

    // =======================================================================
    // interrupt events
    always_comb begin
        events                      = '0;
        events[`EVT_MISMATCH_BIT]   = ce && phase == phase_init
                                      && mismatch_now;
        events[`EVT_WRAP_BIT]       = step_en && wrapped
                                      && (rev_pos ^ rev_neg);
        events[`EVT_WR_DONE_BIT]    = ce && enc_wr_req
                                      && limit_mismatch_alarm;
        events[`EVT_WR_REFUSED_BIT] = ce && enc_wr_req
                                      && !limit_mismatch_alarm;
    end

    // a read clears only the bits it returned; new events always win
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= '0;
        end else if (ce) begin
            if (rd_take && avs_address == `OFS_IRQ_STATUS) begin
                irq_status <= (irq_status & ~avs_readdata[`EVT_COUNT-1:0])
                              | events;
            end else begin
                irq_status <= irq_status | events;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask <= `MASK_DEFAULT;
        end else if (wr_take && avs_address == `OFS_IRQ_MASK
                     && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[`EVT_COUNT-1:0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule
`default_nettype wire

// ### bench/absolute_encoder_model.sv
// Purpose: encoder at the far side, holding its own multiturn limit
// Assumes: write strobe and data synchronous to mclk
// Notes:   stored limit is non-volatile, so drive resets never touch it
`timescale 1ns/1ps
`default_nettype none
`include "multiturn_limit_counter_consts.svh"

module absolute_encoder_model
    import multiturn_limit_counter_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      encoder_write_strobe,
    input  wire turns_type encoder_write_data,
    input  wire turns_type preset_turns,
    output turns_type      encoder_limit,
    output turns_type      encoder_turns
);
    initial encoder_limit = `LIMIT_DEFAULT;
    always @(posedge mclk) begin
        if (encoder_write_strobe === 1'b1) begin
            encoder_limit <= encoder_write_data;
        end
    end
    assign encoder_turns = preset_turns;
endmodule
`default_nettype wire

// ### bench/multiturn_limit_counter_properties.sv
// Purpose: port-level timing properties of the multiturn counter
// Assumes: one mclk domain, arst_n asynchronous active low
// Notes:   the active limit is not visible here; steps are checked loosely
`timescale 1ns/1ps
`default_nettype none

module multiturn_limit_counter_properties
    import multiturn_limit_counter_pkg::*;
(
    input wire logic      mclk,
    input wire logic      arst_n,
    input wire logic      ce,
    input wire logic      avs_read,
    input wire logic      avs_write,
    input wire logic      avs_waitrequest,
    input wire logic      rev_pos,
    input wire logic      rev_neg,
    input wire logic      encoder_write_strobe,
    input wire turns_type multiturn_count,
    input wire logic      count_valid,
    input wire logic      limit_mismatch_alarm,
    input wire logic      alarm_code_bit1_n,
    input wire logic      alarm_code_bit2_n,
    input wire logic      alarm_code_bit3_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // steps
    sequence s_new_req;
        ce && (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_pos;
        count_valid && ce && rev_pos && !rev_neg;
    endsequence
    sequence s_neg;
        count_valid && ce && rev_neg && !rev_pos;
    endsequence
    // ==========================================
    // assertions
    a_wait_one: assert property (s_new_req |-> s_one_wait)
        else $error("bus answer not after one wait cycle");
    a_code_bit2_off: assert property (alarm_code_bit2_n)
        else $error("alarm code bit2 not high");
    a_codes_track_alarm: assert property (count_valid |->
        alarm_code_bit1_n == !$past(limit_mismatch_alarm)
        && alarm_code_bit3_n == alarm_code_bit1_n)
        else $error("alarm codes disagree with alarm");
    a_strobe_single: assert property (
        encoder_write_strobe |=> !encoder_write_strobe)
        else $error("encoder write strobe longer than one cycle");
    a_strobe_needs_alarm: assert property (
        encoder_write_strobe |->
        $past(limit_mismatch_alarm) && !limit_mismatch_alarm)
        else $error("strobe without alarm or alarm not cleared");
    a_alarm_drop_cause: assert property (
        $fell(limit_mismatch_alarm) |-> encoder_write_strobe || !count_valid)
        else $error("alarm dropped without cause");
    a_alarm_at_init: assert property (
        $rose(limit_mismatch_alarm) |-> !count_valid)
        else $error("alarm raised outside init");
    a_pos_step: assert property (s_pos |=> !count_valid
        || multiturn_count == $past(multiturn_count) + 16'h0001
        || multiturn_count == 16'h0000)
        else $error("positive step wrong");
    a_neg_step: assert property (s_neg |=> !count_valid
        || multiturn_count == $past(multiturn_count) - 16'h0001
        || $past(multiturn_count) == 16'h0000)
        else $error("negative step wrong");
    a_hold_count: assert property (
        count_valid && ce && rev_pos == rev_neg
        |=> !count_valid || $stable(multiturn_count))
        else $error("count moved without a step");
endmodule

bind multiturn_limit_counter multiturn_limit_counter_properties props (
    .mclk, .arst_n, .ce, .avs_read, .avs_write, .avs_waitrequest,
    .rev_pos, .rev_neg, .encoder_write_strobe, .multiturn_count,
    .count_valid, .limit_mismatch_alarm, .alarm_code_bit1_n,
    .alarm_code_bit2_n, .alarm_code_bit3_n);
`default_nettype wire

// ### bench/multiturn_limit_counter_test.sv
// Purpose: self-checking bench with a behavioural turn-count model
// Assumes: ce low for one short stretch; full byte lanes always
// Notes:   wrap events are checked once after the signed rollover, masked out of status reads after the random pulses
`timescale 1ns/1ps
`default_nettype none
`include "multiturn_limit_counter_consts.svh"

module multiturn_limit_counter_test
    import multiturn_limit_counter_pkg::*;
;
    logic        mclk, arst_n, ce, avs_read, avs_write, rev_pos, rev_neg;
    logic        avs_waitrequest, encoder_write_strobe, count_valid, irq;
    logic        limit_mismatch_alarm, chk_on;
    logic        alarm_code_bit1_n, alarm_code_bit2_n, alarm_code_bit3_n;
    logic [4:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, r;
    turns_type   encoder_limit, encoder_turns, encoder_write_data;
    turns_type   multiturn_count, preset_turns;
    int          n_errors, compares, seed, m_count, m_limit, m_usage, i;

    multiturn_limit_counter uut (.mclk(mclk), .arst_n(arst_n), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rev_pos(rev_pos),
        .rev_neg(rev_neg), .encoder_limit(encoder_limit),
        .encoder_turns(encoder_turns),
        .encoder_write_strobe(encoder_write_strobe),
        .encoder_write_data(encoder_write_data),
        .multiturn_count(multiturn_count), .count_valid(count_valid),
        .limit_mismatch_alarm(limit_mismatch_alarm),
        .alarm_code_bit1_n(alarm_code_bit1_n),
        .alarm_code_bit2_n(alarm_code_bit2_n),
        .alarm_code_bit3_n(alarm_code_bit3_n), .irq(irq));
    absolute_encoder_model enc (.mclk(mclk),
        .encoder_write_strobe(encoder_write_strobe),
        .encoder_write_data(encoder_write_data),
        .preset_turns(preset_turns), .encoder_limit(encoder_limit),
        .encoder_turns(encoder_turns));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================
    // shared tasks
    task automatic complete_run();
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic timeout();
        n_errors++;
        complete_run();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge mclk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) timeout();
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_valid(input logic v);
        int k;
        for (k = 0; k < 30; k++) begin
            @(posedge mclk);
            if (count_valid === v) break;
        end
        if (k == 30) timeout();
    endtask
    task automatic start(input int c);
        #1;
        m_count = c;
        chk_on = 1'b1;
    endtask
    task automatic pulse(input logic p, input logic n);
        @(posedge mclk);
        rev_pos <= p;
        rev_neg <= n;
    endtask
    task automatic restart(input logic [31:0] s, input turns_type t);
        chk_on = 1'b0;
        preset_turns <= t;
        bus(1'b1, `OFS_SETTING, s);
        rdchk(`OFS_ACTIVE_LIMIT, m_limit);
        bus(1'b1, `OFS_CONTROL, 32'h1);
        wait_valid(1'b0);
        wait_valid(1'b1);
        m_limit = s[15:0];
        m_usage = s[16];
        start(m_usage == 1 ? 0 : t);
    endtask
    function automatic int next_turn(int c, logic p, logic n);
        if (p === n) return c;
        if (m_usage == 0 && m_limit != 65535) begin
            if (p) return (c == m_limit) ? 0 : c + 1;
            return (c == 0) ? m_limit : c - 1;
        end
        return (p ? c + 1 : c - 1) & 32'h0000FFFF;
    endfunction
    always @(posedge mclk) begin
        if (chk_on) begin
            check({16'h0000, multiturn_count}, m_count);
            m_count = next_turn(m_count, rev_pos, rev_neg);
        end
    end
    // ==========================================
    // main sequence
    initial begin
        {arst_n, avs_read, avs_write, rev_pos, rev_neg, chk_on} = 6'h00;
        {n_errors, compares, m_usage} = 0;
        {ce, avs_byteenable, avs_address, avs_writedata} = 42'h3E000000000;
        seed = 9;
        m_limit = 65535;
        preset_turns = 16'h7FFF;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        wait_valid(1'b1);
        check({limit_mismatch_alarm, alarm_code_bit1_n, alarm_code_bit2_n,
               alarm_code_bit3_n}, 32'h7);
        rdchk(`OFS_SETTING, 32'h0000FFFF);
        rdchk(`OFS_IRQ_MASK, 32'h0);
        rdchk(5'h1C, 32'h0);
        start(32'h7FFF);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b1);
        pulse(1'b0, 1'b0);
        rdchk(`OFS_IRQ_STATUS, 32'h2);
        bus(1'b1, `OFS_IRQ_MASK, 32'hF);
        rdchk(`OFS_IRQ_MASK, 32'hF);
        restart(32'h00000004, 16'h0003);
        check({alarm_code_bit1_n, alarm_code_bit2_n, alarm_code_bit3_n,
               limit_mismatch_alarm, irq}, 32'h0B);
        rdchk(`OFS_IRQ_STATUS, 32'h1);
        rdchk(`OFS_IRQ_STATUS, 32'h0);
        check(irq, 1'b0);
        for (i = 0; i < 60; i++) begin
            r = $random(seed);
            pulse(r[0], r[1]);
        end
        pulse(1'b0, 1'b0);
        bus(1'b1, `OFS_CONTROL, 32'h2);
        for (i = 0; i < 10 && encoder_write_strobe !== 1'b1; i++) begin
            @(posedge mclk);
        end
        if (i == 10) timeout();
        check(encoder_write_data, 16'h0004);
        repeat (2) @(posedge mclk);
        check({encoder_limit, limit_mismatch_alarm, alarm_code_bit1_n,
               alarm_code_bit3_n}, 32'h23);
        bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
        check(rd & 32'hD, 32'h4);
        bus(1'b1, `OFS_CONTROL, 32'h2);
        for (i = 0; i < 8; i++) begin
            @(posedge mclk);
            check(encoder_write_strobe, 1'b0);
        end
        bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
        check(rd & 32'hD, 32'h8);
        restart(32'h00000004, 16'h0002);
        check(limit_mismatch_alarm, 1'b0);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b0);
        restart(32'h00010004, 16'h0002);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b0);
        chk_on = 1'b0;
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        m_limit = 65535;
        m_usage = 0;
        wait_valid(1'b1);
        check(limit_mismatch_alarm, 1'b1);
        start(2);
        rdchk(`OFS_SETTING, 32'h0000FFFF);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b0);
        chk_on = 1'b0;
        ce <= 1'b0;
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b0);
        ce <= 1'b1;
        repeat (2) @(posedge mclk);
        check(multiturn_count, 16'h0003);
        complete_run();
    end
endmodule
`default_nettype wire
